// ---- common/epic_regs.svh ----
/*
  Register map, bit positions, reset values and vector numbers of the
  exception and interrupt controller. Assumes it is included by bare name
  from the package and the design files.
*/
// Contract
// RULE1 - Reset beats every other exception; on release it starts at vector zero.
// RULE2 - Watchdog overflow resets the chip exactly like the reset pin.
// RULE3 - While the CPU global mask bit is one, all requests are held off.
// RULE4 - Interrupt handling starts only after the current instruction or handling ends.
// RULE5 - Lowest pending vector number wins; vector 0 highest, 20 lowest.
// RULE6 - First pin vector 4, second pin 5, event pin 6, wakeup pins 9.
// RULE7 - Timer A 11, event counter overflow 12, timer F low 14, high 15.
// RULE8 - Serial port causes share 18, A/D end 19, direct transition 20.
// RULE9 - Edge select bits 7 to 5 always read one, whatever is written.
// RULE10 - Edge select bits 1 and 0: zero falling, one rising, per pin.
// RULE11 - Software writes zero to every reserved write-only bit.
// RULE12 - Enable one bit 7 gates the timer A overflow request.
// RULE13 - Enable one bit 5 gates all eight wakeup requests together.
// RULE14 - Enable one bits 2, 1, 0 gate event pin, second, first pin.
// RULE15 - Enable two bit 7 gates direct transition, bit 6 A/D end.
// RULE16 - Enable two bit 3 gates timer F high, bit 2 timer F low.
// RULE17 - Enable two bit 0 gates the event counter overflow request.
// RULE18 - Flags stay set on acceptance; only a software zero write clears them.
// RULE19 - Timer A flag bit 7 sets when the counter wraps from FF to 00.
// RULE20 - Request flags one bit 5 always reads one and ignores writes.
// RULE21 - Event pin flag bit 2 sets on its selected edge in interrupt mode.
// RULE22 - Pin flags bit 1 and 0 set on their selected edge in interrupt mode.
// RULE23 - Writing zero clears a request flag; writing one leaves it alone.
// RULE24 - Each request to the CPU is its flag AND its enable; the code passes serial slot 18 straight from serial_port_irq.
// RULE25 - Pins are synchronised before edge detection; one flag set per edge.
`ifndef EPIC_REGS_SVH
`define EPIC_REGS_SVH

// Byte offsets on the register bus
`define EPIC_OFF_EDGE_SEL 8'h00
`define EPIC_OFF_EN_ONE 8'h04
`define EPIC_OFF_EN_TWO 8'h08
`define EPIC_OFF_FLAGS_ONE 8'h0C
`define EPIC_OFF_FLAGS_TWO 8'h10
`define EPIC_OFF_WK_FLAGS 8'h14
`define EPIC_OFF_WK_EDGE 8'h18
`define EPIC_OFF_PIN_MODE 8'h1C
`define EPIC_OFF_STATUS 8'h20

// Reset values and writable bit masks
`define EPIC_EDGE_SEL_RST 8'hE0
`define EPIC_FLAGS_ONE_RST 8'h20
`define EPIC_ZERO_RST 8'h00
`define EPIC_PIN_MODE_RST 16'h0000
`define EPIC_EN_ONE_WMASK 8'hA7
`define EPIC_EN_TWO_WMASK 8'hCD
`define EPIC_FLAGS_ONE_WMASK 8'h87
`define EPIC_FLAGS_TWO_WMASK 8'hCD

// Bit positions
`define EPIC_BIT_TIMER_A 7
`define EPIC_BIT_WAKEUP 5
`define EPIC_BIT_EVENT_PIN 2
`define EPIC_BIT_SECOND_PIN 1
`define EPIC_BIT_FIRST_PIN 0
`define EPIC_BIT_DIRECT 7
`define EPIC_BIT_ADC 6
`define EPIC_BIT_TF_HIGH 3
`define EPIC_BIT_TF_LOW 2
`define EPIC_BIT_EC_OVF 0
`define EPIC_BIT_EVENT_EDGE 3

// Vector numbers
`define EPIC_VEC_RESET 5'h00
`define EPIC_VEC_FIRST_PIN 5'h04
`define EPIC_VEC_SECOND_PIN 5'h05
`define EPIC_VEC_EVENT_PIN 5'h06
`define EPIC_VEC_WAKEUP 5'h09
`define EPIC_VEC_TIMER_A 5'h0B
`define EPIC_VEC_EC_OVF 5'h0C
`define EPIC_VEC_TF_LOW 5'h0E
`define EPIC_VEC_TF_HIGH 5'h0F
`define EPIC_VEC_SERIAL 5'h12
`define EPIC_VEC_ADC 5'h13
`define EPIC_VEC_DIRECT 5'h14
`define EPIC_NUM_VEC 21

// Timer A wrap values
`define EPIC_TA_MAX 8'hFF
`define EPIC_TA_ZERO 8'h00

`endif

// ---- common/epic_pkg.sv ----
/*
  Types shared by the interrupt controller files. Assumes epic_regs.svh
  is on the include path.
*/
package epic_pkg;
  `include "epic_regs.svh"

  typedef logic [4:0] epic_vec_t;
  typedef logic [15:0] epic_addr_t;
  typedef logic [`EPIC_NUM_VEC-1:0] epic_req_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_RUN = 3'b010,
    ST_HANDLE = 3'b100
  } epic_state_e;
endpackage : epic_pkg

// ---- design/epic_edge_detect.sv ----
/*
  Pin synchroniser and selectable edge detector for the external interrupt
  pins. Assumes pins are asynchronous to clk; one pulse per qualifying edge.
*/
`timescale 1ns/1ps
module epic_edge_detect #(
  parameter int WIDTH = 11
) (
  input logic clk,
  input logic rst_n,
  input logic [WIDTH-1:0] pin_async,
  input logic [WIDTH-1:0] rise_sel,
  output logic [WIDTH-1:0] edge_pulse
);
  logic [WIDTH-1:0] meta_q, sync_q, prev_q;
  logic [2:0] armed_q, armed_d;

  // Hold off detection until sync and history hold real pin levels
  always_comb begin
    armed_d = {armed_q[1:0], 1'h1};
  end

  // RULE25 two-flop sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
      armed_q <= 3'h0;
    end else begin
      meta_q <= pin_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
      armed_q <= armed_d;
    end
  end

  // RULE10 edge polarity choice
  always_comb begin
    edge_pulse = '0;
    if (armed_q[2]) begin
      edge_pulse = (rise_sel & sync_q & ~prev_q) | (~rise_sel & ~sync_q & prev_q);
    end
  end
endmodule : epic_edge_detect

// ---- design/epic_ctrl.sv ----
/*
  Exception and interrupt controller: APB register file, request flags,
  enables, fixed priority and the exception start handshake to the CPU.
  Assumes a CPU core that pulses cpu_boundary when an instruction or an
  exception handling sequence completes, and peripherals on pclk.
*/
`timescale 1ns/1ps
`include "epic_regs.svh"
module epic_ctrl (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic reset_pin_n,
  input logic watchdog_ovf,
  input logic first_ext_irq_pin,
  input logic second_ext_irq_pin,
  input logic event_counter_irq_pin,
  input logic [7:0] wakeup_pins,
  input logic [7:0] timer_a_count,
  input logic event_counter_ovf,
  input logic timer_f_low_evt,
  input logic timer_f_high_evt,
  input logic [3:0] serial_port_irq,
  input logic adc_end,
  input logic direct_transition,
  input logic cpu_int_mask,
  input logic cpu_boundary,
  output logic exc_start,
  output epic_pkg::epic_vec_t exc_vector,
  output epic_pkg::epic_addr_t exc_vec_addr,
  output logic irq_pending,
  output logic chip_reset
);
  import epic_pkg::*;

  // Lowest set index wins, so vector 0 is the highest priority
  function automatic epic_vec_t epic_top_vec(input epic_req_t r);
    epic_vec_t v;
    v = 5'h00;
    for (int i = `EPIC_NUM_VEC - 1; i >= 0; i--) begin
      if (r[i]) begin
        v = 5'(i);
      end
    end
    return v;
  endfunction : epic_top_vec

  // Each vector slot is one 16-bit word, two bytes apart
  function automatic epic_addr_t epic_vec_addr(input epic_vec_t v);
    return {10'h000, v, 1'h0};
  endfunction : epic_vec_addr

  logic rst_meta_q, rst_sync_q;
  logic chip_rst;
  logic [1:0] ext_irq_edge_select_q, ext_irq_edge_select_d;
  logic [7:0] irq_enable_one_q, irq_enable_one_d;
  logic [7:0] irq_enable_two_q, irq_enable_two_d;
  logic [7:0] irq_request_flags_one_q, irq_request_flags_one_d;
  logic [7:0] irq_request_flags_two_q, irq_request_flags_two_d;
  logic [7:0] wakeup_flags_q, wakeup_flags_d;
  logic [7:0] wakeup_edge_select_q, wakeup_edge_select_d;
  logic [15:0] pin_mode_q, pin_mode_d;
  logic [7:0] ta_prev_q;
  logic ta_wrap;
  logic [10:0] pin_edge;
  logic [7:0] set_one, set_two, clr_one, clr_two, clr_wk, wd;
  logic apb_access, apb_done, wr_en, mapped;
  logic [31:0] rdata;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  epic_req_t req, req_q;
  logic any_req;
  epic_vec_t top_vec;
  epic_state_e state_q, state_d;
  logic exc_start_q, exc_start_d;
  epic_vec_t exc_vector_q, exc_vector_d;
  epic_addr_t exc_vec_addr_q, exc_vec_addr_d;
  logic irq_pending_q, irq_pending_d;
  logic chip_reset_q;

  // Reset pin crosses into pclk before anything looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_meta_q <= 1'h0;
      rst_sync_q <= 1'h0;
    end else begin
      rst_meta_q <= reset_pin_n;
      rst_sync_q <= rst_meta_q;
    end
  end

  // RULE2 watchdog joins pin reset
  assign chip_rst = !rst_sync_q || watchdog_ovf;

  // RULE25 synchronised pin edges
  epic_edge_detect #(
    .WIDTH(11)
  ) u_edges (
    .clk(pclk),
    .rst_n(presetn),
    .pin_async({wakeup_pins, event_counter_irq_pin, second_ext_irq_pin, first_ext_irq_pin}),
    .rise_sel({wakeup_edge_select_q, pin_mode_q[`EPIC_BIT_EVENT_EDGE], ext_irq_edge_select_q}),
    .edge_pulse(pin_edge)
  );

  // RULE19 wrap from max to zero
  assign ta_wrap = (ta_prev_q == `EPIC_TA_MAX) && (timer_a_count == `EPIC_TA_ZERO);

  // APB handshake: one wait state, so pready and data both leave flops
  assign apb_access = psel && penable;
  assign apb_done = apb_access && pready_q;
  assign wr_en = apb_done && pwrite && mapped;
  assign wd = pwdata[7:0];

  // Read mux and address decode
  always_comb begin
    mapped = 1'h1;
    rdata = 32'h00000000;
    case (paddr)
      // RULE9 top bits read one
      `EPIC_OFF_EDGE_SEL: rdata = {24'h000000, `EPIC_EDGE_SEL_RST | {6'h00, ext_irq_edge_select_q}};
      `EPIC_OFF_EN_ONE: rdata = {24'h000000, irq_enable_one_q};
      `EPIC_OFF_EN_TWO: rdata = {24'h000000, irq_enable_two_q};
      `EPIC_OFF_FLAGS_ONE: rdata = {24'h000000, irq_request_flags_one_q};
      `EPIC_OFF_FLAGS_TWO: rdata = {24'h000000, irq_request_flags_two_q};
      `EPIC_OFF_WK_FLAGS: rdata = {24'h000000, wakeup_flags_q};
      `EPIC_OFF_WK_EDGE: rdata = {24'h000000, wakeup_edge_select_q};
      `EPIC_OFF_PIN_MODE: rdata = {16'h0000, pin_mode_q};
      `EPIC_OFF_STATUS: rdata = {25'h0000000, state_q == ST_HANDLE, any_req, top_vec};
      default: mapped = 1'h0;
    endcase
  end

  // Bus answer registers
  always_comb begin
    pready_d = apb_access && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d = (pready_d && !pwrite && mapped) ? rdata : 32'h00000000;
  end

  // Hardware set sources, one bit per flag
  always_comb begin
    set_one = 8'h00;
    set_one[`EPIC_BIT_TIMER_A] = ta_wrap;
    // RULE21 event pin in interrupt mode
    set_one[`EPIC_BIT_EVENT_PIN] = pin_edge[2] && pin_mode_q[2];
    // RULE22 irq pins in interrupt mode
    set_one[`EPIC_BIT_SECOND_PIN] = pin_edge[1] && pin_mode_q[1];
    set_one[`EPIC_BIT_FIRST_PIN] = pin_edge[0] && pin_mode_q[0];
    set_two = 8'h00;
    set_two[`EPIC_BIT_DIRECT] = direct_transition;
    set_two[`EPIC_BIT_ADC] = adc_end;
    set_two[`EPIC_BIT_TF_HIGH] = timer_f_high_evt;
    set_two[`EPIC_BIT_TF_LOW] = timer_f_low_evt;
    set_two[`EPIC_BIT_EC_OVF] = event_counter_ovf;
  end

  // RULE23 zero writes clear only
  always_comb begin
    clr_one = (wr_en && paddr == `EPIC_OFF_FLAGS_ONE) ? (~wd & `EPIC_FLAGS_ONE_WMASK) : 8'h00;
    clr_two = (wr_en && paddr == `EPIC_OFF_FLAGS_TWO) ? (~wd & `EPIC_FLAGS_TWO_WMASK) : 8'h00;
    clr_wk = (wr_en && paddr == `EPIC_OFF_WK_FLAGS) ? ~wd : 8'h00;
  end

  // Register file next state; a chip reset restores every reset value
  always_comb begin
    ext_irq_edge_select_d = ext_irq_edge_select_q;
    irq_enable_one_d = irq_enable_one_q;
    irq_enable_two_d = irq_enable_two_q;
    wakeup_edge_select_d = wakeup_edge_select_q;
    pin_mode_d = pin_mode_q;
    // RULE18 set beats clear
    irq_request_flags_one_d = (irq_request_flags_one_q & ~clr_one) | set_one;
    irq_request_flags_two_d = (irq_request_flags_two_q & ~clr_two) | set_two;
    wakeup_flags_d = (wakeup_flags_q & ~clr_wk) | (pin_edge[10:3] & pin_mode_q[15:8]);
    // RULE20 bit five pinned high
    irq_request_flags_one_d = irq_request_flags_one_d | `EPIC_FLAGS_ONE_RST;
    // RULE11 reserved bits dropped
    if (wr_en && paddr == `EPIC_OFF_EDGE_SEL) begin
      ext_irq_edge_select_d = wd[1:0];
    end
    if (wr_en && paddr == `EPIC_OFF_EN_ONE) begin
      irq_enable_one_d = wd & `EPIC_EN_ONE_WMASK;
    end
    if (wr_en && paddr == `EPIC_OFF_EN_TWO) begin
      irq_enable_two_d = wd & `EPIC_EN_TWO_WMASK;
    end
    if (wr_en && paddr == `EPIC_OFF_WK_EDGE) begin
      wakeup_edge_select_d = wd;
    end
    if (wr_en && paddr == `EPIC_OFF_PIN_MODE) begin
      pin_mode_d = pwdata[15:0];
    end
    // RULE1 reset restores state
    if (chip_rst) begin
      ext_irq_edge_select_d = 2'h0;
      irq_enable_one_d = `EPIC_ZERO_RST;
      irq_enable_two_d = `EPIC_ZERO_RST;
      irq_request_flags_one_d = `EPIC_FLAGS_ONE_RST;
      irq_request_flags_two_d = `EPIC_ZERO_RST;
      wakeup_flags_d = `EPIC_ZERO_RST;
      wakeup_edge_select_d = `EPIC_ZERO_RST;
      pin_mode_d = `EPIC_PIN_MODE_RST;
    end
  end

  // RULE24 flag AND enable, serial slot excepted
  always_comb begin
    req = '0;
    // RULE6 RULE14 pin slots, enables
    req[`EPIC_VEC_FIRST_PIN] = irq_request_flags_one_q[`EPIC_BIT_FIRST_PIN] && irq_enable_one_q[`EPIC_BIT_FIRST_PIN];
    req[`EPIC_VEC_SECOND_PIN] = irq_request_flags_one_q[`EPIC_BIT_SECOND_PIN]
      && irq_enable_one_q[`EPIC_BIT_SECOND_PIN];
    req[`EPIC_VEC_EVENT_PIN] = irq_request_flags_one_q[`EPIC_BIT_EVENT_PIN] && irq_enable_one_q[`EPIC_BIT_EVENT_PIN];
    // RULE13 one wakeup enable
    req[`EPIC_VEC_WAKEUP] = (|wakeup_flags_q) && irq_enable_one_q[`EPIC_BIT_WAKEUP];
    // RULE7 RULE12 timer A slot, enable
    req[`EPIC_VEC_TIMER_A] = irq_request_flags_one_q[`EPIC_BIT_TIMER_A] && irq_enable_one_q[`EPIC_BIT_TIMER_A];
    // RULE7 RULE17 counter overflow slot
    req[`EPIC_VEC_EC_OVF] = irq_request_flags_two_q[`EPIC_BIT_EC_OVF] && irq_enable_two_q[`EPIC_BIT_EC_OVF];
    // RULE7 RULE16 timer F slots
    req[`EPIC_VEC_TF_LOW] = irq_request_flags_two_q[`EPIC_BIT_TF_LOW] && irq_enable_two_q[`EPIC_BIT_TF_LOW];
    req[`EPIC_VEC_TF_HIGH] = irq_request_flags_two_q[`EPIC_BIT_TF_HIGH] && irq_enable_two_q[`EPIC_BIT_TF_HIGH];
    // RULE8 serial causes share one slot; the port gates them itself
    req[`EPIC_VEC_SERIAL] = |serial_port_irq;
    // RULE15 A/D and direct enables
    req[`EPIC_VEC_ADC] = irq_request_flags_two_q[`EPIC_BIT_ADC] && irq_enable_two_q[`EPIC_BIT_ADC];
    req[`EPIC_VEC_DIRECT] = irq_request_flags_two_q[`EPIC_BIT_DIRECT] && irq_enable_two_q[`EPIC_BIT_DIRECT];
  end

  // RULE5 fixed priority pick
  assign top_vec = epic_top_vec(req);
  assign any_req = |req;

  // Exception sequencer; it never clears a flag, software does that
  always_comb begin
    state_d = state_q;
    exc_start_d = 1'h0;
    exc_vector_d = exc_vector_q;
    exc_vec_addr_d = exc_vec_addr_q;
    // RULE3 mask holds requests
    irq_pending_d = any_req && !cpu_int_mask && !chip_rst;
    if (chip_rst) begin
      // RULE1 reset wins
      state_d = ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: begin
          // RULE1 start at slot zero
          exc_start_d = 1'h1;
          exc_vector_d = `EPIC_VEC_RESET;
          exc_vec_addr_d = epic_vec_addr(`EPIC_VEC_RESET);
          state_d = ST_HANDLE;
        end
        ST_RUN: begin
          // RULE4 wait for boundary
          if (cpu_boundary && any_req && !cpu_int_mask) begin
            exc_start_d = 1'h1;
            exc_vector_d = top_vec;
            exc_vec_addr_d = epic_vec_addr(top_vec);
            state_d = ST_HANDLE;
          end
        end
        ST_HANDLE: begin
          if (cpu_boundary) begin
            state_d = ST_RUN;
          end
        end
        default: state_d = ST_RESET;
      endcase
    end
  end

  // All state registers except the reset pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_edge_select_q <= 2'h0;
      irq_enable_one_q <= `EPIC_ZERO_RST;
      irq_enable_two_q <= `EPIC_ZERO_RST;
      irq_request_flags_one_q <= `EPIC_FLAGS_ONE_RST;
      irq_request_flags_two_q <= `EPIC_ZERO_RST;
      wakeup_flags_q <= `EPIC_ZERO_RST;
      wakeup_edge_select_q <= `EPIC_ZERO_RST;
      pin_mode_q <= `EPIC_PIN_MODE_RST;
      ta_prev_q <= `EPIC_TA_ZERO;
      prdata_q <= 32'h00000000;
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      state_q <= ST_RESET;
      exc_start_q <= 1'h0;
      exc_vector_q <= `EPIC_VEC_RESET;
      exc_vec_addr_q <= 16'h0000;
      irq_pending_q <= 1'h0;
      chip_reset_q <= 1'h1;
      req_q <= '0;
    end else begin
      ext_irq_edge_select_q <= ext_irq_edge_select_d;
      irq_enable_one_q <= irq_enable_one_d;
      irq_enable_two_q <= irq_enable_two_d;
      irq_request_flags_one_q <= irq_request_flags_one_d;
      irq_request_flags_two_q <= irq_request_flags_two_d;
      wakeup_flags_q <= wakeup_flags_d;
      wakeup_edge_select_q <= wakeup_edge_select_d;
      pin_mode_q <= pin_mode_d;
      ta_prev_q <= timer_a_count;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      state_q <= state_d;
      exc_start_q <= exc_start_d;
      exc_vector_q <= exc_vector_d;
      exc_vec_addr_q <= exc_vec_addr_d;
      irq_pending_q <= irq_pending_d;
      chip_reset_q <= chip_rst;
      req_q <= req;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign exc_start = exc_start_q;
  assign exc_vector = exc_vector_q;
  assign exc_vec_addr = exc_vec_addr_q;
  assign irq_pending = irq_pending_q;
  assign chip_reset = chip_reset_q;

  // Checks on the sequencer, flags and register view
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_reset_holds_off: assert property (chip_rst |=> state_q == ST_RESET && !exc_start_q) // RULE1
    else $error("Reset did not hold the sequencer");
  a_reset_vector_zero: assert property (chip_rst ##1 !chip_rst |=> exc_start_q && exc_vec_addr_q == 16'h0000) // RULE1
    else $error("Reset release did not start at slot zero");
  a_watchdog_reset: assert property (watchdog_ovf |=> chip_reset_q && irq_request_flags_two_q == 8'h00) // RULE2
    else $error("Watchdog overflow did not reset");
  a_mask_blocks: assert property (cpu_int_mask && state_q == ST_RUN |=> !exc_start_q) // RULE3
    else $error("Interrupt started while masked");
  a_start_boundary: assert property (exc_start_q && $past(state_q) == ST_RUN |-> $past(cpu_boundary)) // RULE4
    else $error("Interrupt started off a boundary");
  a_priority_pick: assert property (exc_start_q && $past(state_q) == ST_RUN |->
      req_q[exc_vector_q] && ((req_q & ((21'h000001 << exc_vector_q) - 21'h000001)) == 21'h000000)) // RULE5
    else $error("Lower priority request served first");
  a_wakeup_vector: assert property (exc_start_q && exc_vector_q == `EPIC_VEC_WAKEUP |->
      $past(irq_enable_one_q[`EPIC_BIT_WAKEUP]) && $past(wakeup_flags_q) != 8'h00) // RULE13
    else $error("Wakeup vector without gated flag");
  a_edge_sel_ones: assert property (pready_q && !pslverr_q && !pwrite && paddr == `EPIC_OFF_EDGE_SEL
      |-> prdata_q[7:5] == 3'h7 && prdata_q[4:2] == 3'h0) // RULE9
    else $error("Edge select upper bits not one");
  a_flag_sticky: assert property (irq_request_flags_one_q[`EPIC_BIT_FIRST_PIN] && !chip_rst
      && clr_one[`EPIC_BIT_FIRST_PIN] == 1'h0 |=> irq_request_flags_one_q[`EPIC_BIT_FIRST_PIN]) // RULE18
    else $error("Request flag dropped without a zero write");
  a_bit_five_one: assert property (irq_request_flags_one_q[5]) // RULE20
    else $error("Reserved flag bit lost its one");
  a_timer_wrap: assert property (ta_wrap && !chip_rst |=> irq_request_flags_one_q[`EPIC_BIT_TIMER_A]) // RULE19
    else $error("Timer A wrap did not set its flag");

  c_reset_start: cover property (chip_rst ##1 !chip_rst ##1 exc_start_q);
  c_wakeup_start: cover property (exc_start_q && exc_vector_q == `EPIC_VEC_WAKEUP);
  c_flag_clear: cover property (irq_request_flags_one_q[0] ##1 !irq_request_flags_one_q[0]);
  c_serial_start: cover property (exc_start_q && exc_vector_q == `EPIC_VEC_SERIAL);
endmodule : epic_ctrl

// ---- sim/epic_cpu_model.sv ----
/*
  CPU core model for the interrupt controller bench: instruction boundary
  pulses at a bench-chosen spacing and the global mask bit.
  Assumes the controller shares pclk and presetn with it.
*/
`timescale 1ns/1ps
module epic_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic exc_start,
  input wire logic rte,
  input wire logic [2:0] gap,
  output logic cpu_boundary,
  output logic cpu_int_mask
);
  logic [2:0] cnt_q;
  // Boundary every gap+1 cycles, so prompt and slow cores both occur
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      cpu_boundary <= 1'b0;
      cpu_int_mask <= 1'b1;
    end else begin
      cpu_boundary <= (cnt_q >= gap);
      cnt_q <= (cnt_q >= gap) ? 3'h0 : cnt_q + 3'h1;
      // Mask set on entry, dropped only by a return from handling
      if (exc_start) begin
        cpu_int_mask <= 1'b1;
      end else if (rte) begin
        cpu_int_mask <= 1'b0;
      end
    end
  end
endmodule : epic_cpu_model

// ---- sim/tb_top.sv ----
/*
  Self-checking bench for the interrupt controller: APB register checks,
  request sources, masking, priority and both resets.
  Assumes epic_pkg and epic_regs.svh are compiled first.
*/
`timescale 1ns/1ps
`include "epic_regs.svh"
module tb_top;
  import epic_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rte = 0, watchdog_ovf = 0, rstp = 1, evp = 0;
  logic first_ext_irq_pin = 1, second_ext_irq_pin = 1, pready, pslverr, exc_start, cpu_boundary, cpu_int_mask;
  logic [7:0] paddr = 0, timer_a_count = 0, wk = 8'hFF;
  logic [31:0] pwdata = 0, prdata, rs = 32'd32303;
  logic [4:0] pulse = 0;
  logic [3:0] sp = 4'h0;
  logic irq_pending, chip_reset;
  logic [2:0] gap = 3'h2;
  epic_vec_t exc_vector;
  epic_addr_t exc_vec_addr;
  logic [32:0] rdq[$];
  logic [22:0] vq[$];
  int miscompares = 0, n_tests = 0, cyc = 0;
  int bits[5] = '{0, 2, 3, 6, 7};
  logic [4:0] vecs[5] = '{5'h0C, 5'h0E, 5'h0F, 5'h13, 5'h14};

  epic_ctrl u_epic_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reset_pin_n(rstp), .watchdog_ovf, .first_ext_irq_pin, .second_ext_irq_pin,
    .event_counter_irq_pin(evp), .wakeup_pins(wk), .timer_a_count, .event_counter_ovf(pulse[0]),
    .timer_f_low_evt(pulse[1]), .timer_f_high_evt(pulse[2]), .serial_port_irq(sp), .adc_end(pulse[3]),
    .direct_transition(pulse[4]), .cpu_int_mask, .cpu_boundary, .exc_start, .exc_vector, .exc_vec_addr,
    .irq_pending, .chip_reset);
  epic_cpu_model u_epic_cpu_model (.pclk, .presetn, .exc_start, .rte, .gap, .cpu_boundary, .cpu_int_mask);

  always #20 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd

  // Vector, word address (twice the number), pending for interrupts only, reset output low
  function automatic logic [22:0] ev(input logic [4:0] v);
    return {v, 10'h000, v, 1'b0, v != 5'h00, 1'b0};
  endfunction : ev

  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [32:0] e);
    if (!w) rdq.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 16'h0000, {25'h0, e});
  endtask : rd

  task automatic fire(input logic [4:0] m);
    @(posedge pclk);
    pulse <= m;
    @(posedge pclk);
    pulse <= 5'h00;
  endtask : fire

  // Optional return from handling, then wait until every noted start has appeared
  task automatic serve(input logic r);
    if (r) begin
      @(posedge pclk);
      rte <= 1'b1;
      @(posedge pclk);
      rte <= 1'b0;
    end
    while (vq.size() != 0) @(posedge pclk);
  endtask : serve

  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Watcher: every start and every read answer is matched to the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
    if (exc_start === 1'b1) begin
      n_tests++;
      if (vq.size() == 0 || {exc_vector, exc_vec_addr, irq_pending, chip_reset} !== vq[0]) begin
        miscompares++;
        $display("CHECK FAILED exc_vector expected %h seen %h", vq.size() ? vq[0] : 23'h0,
          {exc_vector, exc_vec_addr, irq_pending, chip_reset});
      end
      if (vq.size() != 0) void'(vq.pop_front());
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      n_tests++;
      if ({pslverr, prdata} !== rdq[0]) begin
        miscompares++;
        $display("CHECK FAILED prdata expected %h seen %h", rdq[0], {pslverr, prdata});
      end
      void'(rdq.pop_front());
    end
  end

  initial begin
    logic [31:0] t;
    vq.push_back(ev(`EPIC_VEC_RESET));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    serve(1'b0);
    rd(`EPIC_OFF_EDGE_SEL, 8'hE0);
    wr(`EPIC_OFF_EDGE_SEL, 16'h0003);
    rd(`EPIC_OFF_EDGE_SEL, 8'hE3);
    wr(`EPIC_OFF_FLAGS_ONE, 16'h0000);
    rd(`EPIC_OFF_FLAGS_ONE, 8'h20);
    apb(1'b0, 8'h40, 16'h0000, {1'b1, 32'h0});
    // Timer wrap while still masked after reset: start only after return
    wr(`EPIC_OFF_EN_ONE, 16'h0080);
    @(posedge pclk);
    timer_a_count <= 8'hFF;
    @(posedge pclk);
    timer_a_count <= 8'h00;
    repeat (10) @(posedge pclk);
    vq.push_back(ev(`EPIC_VEC_TIMER_A));
    serve(1'b1);
    wr(`EPIC_OFF_FLAGS_ONE, 16'h0027);
    rd(`EPIC_OFF_FLAGS_ONE, 8'h20);
    serve(1'b1);
    // Pulse sources latch while disabled and are served once enabled
    for (int i = 0; i < 5; i++) begin
      t = rnd();
      gap <= t[2:0];
      fire(5'h01 << i);
      repeat (10) @(posedge pclk);
      vq.push_back(ev(vecs[i]));
      wr(`EPIC_OFF_EN_TWO, 16'h0001 << bits[i]);
      serve(1'b0);
      rd(`EPIC_OFF_FLAGS_TWO, 8'h01 << bits[i]);
      wr(`EPIC_OFF_FLAGS_TWO, {8'h00, 8'hCD & ~(8'h01 << bits[i])});
      serve(1'b1);
    end
    // First pin senses rising only, second pin falling
    wr(`EPIC_OFF_PIN_MODE, 16'h0003);
    wr(`EPIC_OFF_EDGE_SEL, 16'h0001);
    wr(`EPIC_OFF_EN_ONE, 16'h0003);
    @(posedge pclk);
    first_ext_irq_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    vq.push_back(ev(`EPIC_VEC_FIRST_PIN));
    first_ext_irq_pin <= 1'b1;
    serve(1'b0);
    wr(`EPIC_OFF_FLAGS_ONE, 16'h00A6);
    serve(1'b1);
    vq.push_back(ev(`EPIC_VEC_SECOND_PIN));
    second_ext_irq_pin <= 1'b0;
    serve(1'b0);
    wr(`EPIC_OFF_FLAGS_ONE, 16'h00A5);
    // Event pin rises as wakeup pin 0 falls: slot 6 before shared slot 9, then serial slot 18
    wr(`EPIC_OFF_PIN_MODE, 16'h010F);
    wr(`EPIC_OFF_EN_ONE, 16'h0024);
    wk <= 8'hFE;
    evp <= 1'b1;
    repeat (10) @(posedge pclk);
    vq.push_back(ev(`EPIC_VEC_EVENT_PIN));
    serve(1'b1);
    wr(`EPIC_OFF_FLAGS_ONE, 16'h00A3);
    rd(`EPIC_OFF_WK_FLAGS, 8'h01);
    vq.push_back(ev(`EPIC_VEC_WAKEUP));
    serve(1'b1);
    wr(`EPIC_OFF_WK_FLAGS, 16'h00FE);
    sp <= 4'h8;
    vq.push_back(ev(`EPIC_VEC_SERIAL));
    serve(1'b1);
    sp <= 4'h0;
    // Three pending together are served lowest vector first
    wr(`EPIC_OFF_EN_TWO, 16'h00C8);
    fire(5'h1C);
    repeat (10) @(posedge pclk);
    for (int i = 2; i < 5; i++) begin
      vq.push_back(ev(vecs[i]));
      serve(1'b1);
      wr(`EPIC_OFF_FLAGS_TWO, {8'h00, 8'hCD & ~(8'h01 << bits[i])});
    end
    // Reset pin pulled low mid-run restarts at slot zero
    vq.push_back(ev(`EPIC_VEC_RESET));
    rstp <= 1'b0;
    repeat (10) @(posedge pclk);
    rstp <= 1'b1;
    serve(1'b0);
    // Watchdog overflow behaves like the reset pin
    vq.push_back(ev(`EPIC_VEC_RESET));
    watchdog_ovf <= 1'b1;
    @(posedge pclk);
    watchdog_ovf <= 1'b0;
    serve(1'b0);
    rd(`EPIC_OFF_EN_TWO, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
